// File: pkg/host_port_pkg.sv
package host_port_pkg;
	// ==========================================
	// Register map (byte addresses on the CPU bus)
	localparam logic [31:0] OFS_POWER_EMU = 32'h0288_0004;
	localparam logic [31:0] OFS_PORT_CTRL = 32'h0288_0030;
	localparam logic [31:0] OFS_WRITE_ADDR = 32'h0288_0034;
	localparam logic [31:0] OFS_READ_ADDR = 32'h0288_0038;
	localparam logic [31:0] OFS_IRQ_STATUS = 32'h0288_0040;
	localparam logic [31:0] OFS_IRQ_MASK = 32'h0288_0044;
	localparam logic [31:0] OFS_DMA_EVENT = 32'h0288_0048;
	// ==========================================
	// Port control fields
	localparam int CTRL_DUAL_BIT = 0;
	localparam int CTRL_FROM_HOST_BIT = 1;
	localparam int CTRL_TO_HOST_BIT = 2;
	localparam int CTRL_READY_BIT = 3;
	localparam int CTRL_ADDR_SEL_BIT = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] POWER_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_WR_MASK = 32'h0000_0011;
	// ==========================================
	// Access type select codes
	localparam logic [1:0] SEL_CTRL = 2'h0;
	localparam logic [1:0] SEL_ADDR = 2'h1;
	localparam logic [1:0] SEL_DATA = 2'h2;
	localparam logic [1:0] SEL_POWER = 2'h3;
	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int INT_CLK_PERIOD_NS = 60;
	localparam int MIN_GAP_NS = 2 * INT_CLK_PERIOD_NS;
	localparam int MIN_GAP_CYC = (MIN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MEM_LAT_CYC = 2;
	// ==========================================
	// Interrupt status bits
	localparam int IRQ_FROM_HOST = 0;
	localparam int IRQ_BOOT_END = 1;
	localparam int IRQ_ACCESS = 2;
	localparam int IRQ_W = 3;
	localparam int DMA_BOOT_CH = 0;
endpackage : host_port_pkg

// File: pkg/host_port_if.sv
`timescale 1ns/1ps
interface host_port_if;
	logic port_select_n;
	logic data_strobe_a;
	logic data_strobe_b;
	logic [1:0] access_type_select;
	logic read_write_select;
	logic halfword_select;
	logic [31:0] host_data;
	logic [31:0] dev_data;
	logic dev_data_oe;
	logic port_ready_n;
	logic interrupt_to_host;
	modport device (input port_select_n, data_strobe_a, data_strobe_b, access_type_select,
		read_write_select, halfword_select, host_data, output dev_data, dev_data_oe,
		port_ready_n, interrupt_to_host);
	modport host (output port_select_n, data_strobe_a, data_strobe_b, access_type_select,
		read_write_select, halfword_select, host_data, input dev_data, dev_data_oe,
		port_ready_n, interrupt_to_host);
endinterface : host_port_if

// File: hdl/host_port_device.sv
`timescale 1ns/1ps
module host_port_device #(
	parameter int MEM_WORDS = 256
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// Strap
	input wire logic WIDTH_STRAP_PIN,
	// Host link
	host_port_if.device HOST,
	// CPU Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [31:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic WB_ERR_O,
	// Interrupt
	output logic IRQ_O
);
	import host_port_pkg::*;
	initial begin
		if (MEM_WORDS < 2 || MEM_WORDS > 65536) $error("MEM_WORDS out of range");
	end
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_MEM = 2'b01, ST_RDY = 2'b11, ST_GAP = 2'b10} hst_t;
	typedef struct packed {
		hst_t st;
		logic strap_done;
		logic wide;
		logic [31:0] ctrl;
		logic [31:0] power;
		logic [31:0] waddr;
		logic [31:0] raddr;
		logic [15:0] half;
		logic [1:0] sel;
		logic rw;
		logic hw;
		logic [3:0] cnt;
		logic [31:0] rdata;
		logic oe;
		logic [IRQ_W-1:0] stat;
		logic [IRQ_W-1:0] mask;
		logic [31:0] dma_ev;
		logic [31:0] wb_dat;
		logic wb_ack;
		logic wb_err;
	} state_t;
	state_t s_reg, s_next;
	logic [31:0] mem [MEM_WORDS];
	logic strobe_n, mem_we;
	logic [31:0] mem_wdata, mem_addr_q, word_in;
	logic wb_req, host_wr_word, half_first;
	logic [IRQ_W-1:0] ev;
	function automatic logic [31:0] mem_idx(input logic [31:0] a);
		mem_idx = 32'(a[31:2] % MEM_WORDS);
	endfunction : mem_idx
	// ==========================================
	// Host strobe decode
	assign strobe_n = ~(HOST.data_strobe_a ^ HOST.data_strobe_b) | HOST.port_select_n;
	assign half_first = ~s_reg.wide & ~s_reg.hw;
	assign word_in = s_reg.wide ? HOST.host_data : {HOST.host_data[15:0], s_reg.half};
	assign wb_req = WB_CYC_I & WB_STB_I & ~s_reg.wb_ack & ~s_reg.wb_err;
	assign HOST.port_ready_n = (s_reg.st != ST_RDY);
	assign HOST.dev_data = s_reg.rdata;
	assign HOST.dev_data_oe = s_reg.oe;
	assign HOST.interrupt_to_host = s_reg.ctrl[CTRL_TO_HOST_BIT];
	assign WB_DAT_O = s_reg.wb_dat;
	assign WB_ACK_O = s_reg.wb_ack;
	assign WB_ERR_O = s_reg.wb_err;
	assign IRQ_O = |(s_reg.stat & s_reg.mask);
	// ==========================================
	// Memory port
	assign host_wr_word = ~s_reg.rw & (s_reg.sel == SEL_DATA) & ~half_first;
	assign mem_addr_q = mem_idx(s_reg.rw ? s_reg.raddr : s_reg.waddr);
	assign mem_we = (s_reg.st == ST_MEM) && (s_reg.cnt == 4'h0) && host_wr_word;
	assign mem_wdata = word_in;
	always_ff @(posedge REF_CLK) begin
		if (mem_we) begin
			mem[mem_addr_q] <= mem_wdata;
		end
	end
	// ==========================================
	// Next state
	always_comb begin
		s_next = s_reg;
		ev = '0;
		s_next.wb_ack = 1'b0;
		s_next.wb_err = 1'b0;
		if (!s_reg.strap_done) begin
			s_next.strap_done = 1'b1;
			s_next.wide = WIDTH_STRAP_PIN;
		end
		case (s_reg.st)
			ST_IDLE: begin
				s_next.oe = 1'b0;
				if (!strobe_n && s_reg.strap_done) begin
					s_next.sel = HOST.access_type_select;
					s_next.rw = HOST.read_write_select;
					s_next.hw = HOST.halfword_select;
					s_next.cnt = 4'(MEM_LAT_CYC);
					s_next.st = ST_MEM;
				end
			end
			ST_MEM: begin
				if (s_reg.cnt != 4'h0) begin
					s_next.cnt = s_reg.cnt - 4'h1;
				end else begin
					s_next.st = ST_RDY;
					ev[IRQ_ACCESS] = 1'b1;
					if (s_reg.rw) begin
						case (s_reg.sel)
							SEL_CTRL: s_next.rdata = s_reg.ctrl;
							SEL_ADDR: s_next.rdata = s_reg.raddr;
							SEL_DATA: s_next.rdata = mem[mem_addr_q];
							default: s_next.rdata = s_reg.power;
						endcase
						if (!s_reg.wide && s_reg.hw) begin
							s_next.rdata = {16'h0000, s_next.rdata[31:16]};
						end
						s_next.oe = 1'b1;
					end else if (half_first) begin
						s_next.half = HOST.host_data[15:0];
					end else begin
						case (s_reg.sel)
							SEL_CTRL: begin
								s_next.ctrl = (s_reg.ctrl & ~CTRL_WR_MASK) | (word_in & CTRL_WR_MASK);
								if (word_in[CTRL_FROM_HOST_BIT]) begin
									s_next.ctrl[CTRL_FROM_HOST_BIT] = 1'b1;
									ev[IRQ_FROM_HOST] = 1'b1;
									ev[IRQ_BOOT_END] = 1'b1;
								end
							end
							SEL_ADDR: begin
								// Dual mode: the address select bit picks the target
								if (!s_reg.ctrl[CTRL_DUAL_BIT] || !s_reg.ctrl[CTRL_ADDR_SEL_BIT]) begin
									s_next.waddr = word_in;
								end
								if (!s_reg.ctrl[CTRL_DUAL_BIT] || s_reg.ctrl[CTRL_ADDR_SEL_BIT]) begin
									s_next.raddr = word_in;
								end
							end
							SEL_DATA: ;
							default: s_next.power = word_in;
						endcase
					end
				end
			end
			ST_RDY: begin
				if (strobe_n) begin
					s_next.cnt = 4'(MIN_GAP_CYC);
					s_next.oe = 1'b0;
					s_next.st = ST_GAP;
				end
			end
			ST_GAP: begin
				if (s_reg.cnt != 4'h0) begin
					s_next.cnt = s_reg.cnt - 4'h1;
				end else begin
					s_next.st = ST_IDLE;
				end
			end
			default: s_next.st = ST_IDLE;
		endcase
		// CPU register access
		if (wb_req) begin
			s_next.wb_ack = 1'b1;
			case (WB_ADR_I)
				OFS_PORT_CTRL: begin
					s_next.wb_dat = s_reg.ctrl;
					if (WB_WE_I && WB_SEL_I[0]) begin
						s_next.ctrl = (s_next.ctrl & ~CTRL_WR_MASK) | (WB_DAT_I & CTRL_WR_MASK);
						if (WB_DAT_I[CTRL_TO_HOST_BIT]) begin
							s_next.ctrl[CTRL_TO_HOST_BIT] = 1'b1;
						end
						if (WB_DAT_I[CTRL_FROM_HOST_BIT] && !ev[IRQ_FROM_HOST]) begin
							s_next.ctrl[CTRL_FROM_HOST_BIT] = 1'b0;
						end
					end
				end
				OFS_POWER_EMU: begin
					s_next.wb_dat = s_reg.power;
					if (WB_WE_I) begin
						for (int i = 0; i < 4; i++) begin
							if (WB_SEL_I[i]) s_next.power[8*i +: 8] = WB_DAT_I[8*i +: 8];
						end
					end
				end
				OFS_WRITE_ADDR: s_next.wb_dat = s_reg.waddr;
				OFS_READ_ADDR: s_next.wb_dat = s_reg.raddr;
				OFS_IRQ_STATUS: begin
					s_next.wb_dat = 32'(s_reg.stat);
					if (!WB_WE_I) s_next.stat = '0;
				end
				OFS_IRQ_MASK: begin
					s_next.wb_dat = 32'(s_reg.mask);
					if (WB_WE_I && WB_SEL_I[0]) s_next.mask = WB_DAT_I[IRQ_W-1:0];
				end
				OFS_DMA_EVENT: begin
					s_next.wb_dat = s_reg.dma_ev;
					if (WB_WE_I) s_next.dma_ev = s_reg.dma_ev & ~WB_DAT_I;
				end
				default: begin
					s_next.wb_ack = 1'b0;
					s_next.wb_err = 1'b1;
					s_next.wb_dat = 32'h0000_0000;
				end
			endcase
		end
		// Host interrupt host-to-CPU set by host write wins over a CPU clear; CPU-to-host interrupt is never cleared
		if (ev[IRQ_FROM_HOST]) begin
			s_next.ctrl[CTRL_FROM_HOST_BIT] = 1'b1;
		end
		if (ev[IRQ_BOOT_END]) begin
			s_next.dma_ev[DMA_BOOT_CH] = 1'b1;
		end
		s_next.ctrl[CTRL_READY_BIT] = 1'b0;
		s_next.stat = s_next.stat | ev;
	end
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			s_reg <= '{st: ST_IDLE, ctrl: CTRL_RESET, power: POWER_RESET, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end
endmodule : host_port_device

// File: hdl/host_port_host.sv
`timescale 1ns/1ps
module host_port_host (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// Link
	host_port_if.host LINK,
	// User request
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic REQ_WRITE,
	input wire logic REQ_WIDE,
	input wire logic [1:0] REQ_SEL,
	input wire logic [31:0] REQ_DATA,
	// User answer
	output logic RSP_VALID,
	output logic [31:0] RSP_DATA,
	output logic HOST_IRQ
);
	import host_port_pkg::*;
	typedef enum logic [1:0] {H_IDLE = 2'b00, H_WAIT = 2'b01, H_GAP = 2'b11} hh_t;
	typedef struct packed {
		hh_t st;
		logic second;
		logic wide;
		logic wr;
		logic [1:0] sel;
		logic [31:0] data;
		logic strobe;
		logic [3:0] cnt;
		logic rsp_v;
		logic [31:0] rsp;
	} hstate_t;
	hstate_t s_reg, s_next;
	assign REQ_READY = (s_reg.st == H_IDLE) && !s_reg.second;
	assign LINK.port_select_n = ~s_reg.strobe;
	// Writes strobe on one line and reads on the other
	assign LINK.data_strobe_a = s_reg.strobe & s_reg.wr;
	assign LINK.data_strobe_b = s_reg.strobe & ~s_reg.wr;
	assign LINK.access_type_select = s_reg.sel;
	assign LINK.read_write_select = ~s_reg.wr;
	assign LINK.halfword_select = s_reg.second;
	assign LINK.host_data = (s_reg.wide || !s_reg.second) ? s_reg.data : {16'h0000, s_reg.data[31:16]};
	assign RSP_VALID = s_reg.rsp_v;
	assign RSP_DATA = s_reg.rsp;
	assign HOST_IRQ = LINK.interrupt_to_host;
	always_comb begin
		s_next = s_reg;
		s_next.rsp_v = 1'b0;
		case (s_reg.st)
			H_IDLE: begin
				if (s_reg.second) begin
					s_next.strobe = 1'b1;
					s_next.st = H_WAIT;
				end else if (REQ_VALID) begin
					s_next.wr = REQ_WRITE;
					s_next.wide = REQ_WIDE;
					s_next.sel = REQ_SEL;
					s_next.data = REQ_DATA;
					s_next.strobe = 1'b1;
					s_next.st = H_WAIT;
				end
			end
			H_WAIT: begin
				if (!LINK.port_ready_n) begin
					s_next.strobe = 1'b0;
					s_next.cnt = 4'(MIN_GAP_CYC + 1);
					s_next.st = H_GAP;
					if (s_reg.wide) begin
						s_next.rsp = LINK.dev_data;
					end else if (!s_reg.second) begin
						s_next.rsp = {16'h0000, LINK.dev_data[15:0]};
					end else begin
						s_next.rsp = {LINK.dev_data[15:0], s_reg.rsp[15:0]};
					end
				end
			end
			H_GAP: begin
				if (s_reg.cnt != 4'h0) begin
					s_next.cnt = s_reg.cnt - 4'h1;
				end else begin
					s_next.st = H_IDLE;
					if (!s_reg.wide && !s_reg.second) begin
						s_next.second = 1'b1;
					end else begin
						s_next.second = 1'b0;
						s_next.rsp_v = 1'b1;
					end
				end
			end
			default: s_next.st = H_IDLE;
		endcase
	end
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			s_reg <= '{st: H_IDLE, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end
endmodule : host_port_host

// File: test/host_port_assertions.sv
`timescale 1ns/1ps
module host_port_assertions (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// Link
	input wire logic port_select_n,
	input wire logic data_strobe_a,
	input wire logic data_strobe_b,
	input wire logic [1:0] access_type_select,
	input wire logic read_write_select,
	input wire logic halfword_select,
	input wire logic dev_data_oe,
	input wire logic port_ready_n,
	input wire logic interrupt_to_host
);
	logic stb_n;
	assign stb_n = ~(data_strobe_a ^ data_strobe_b) | port_select_n;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	// ==========================================
	// Link checks
	chk_ready_cause: assert property ($fell(port_ready_n) |-> !stb_n)
		else $error("ready fell without strobe");
	chk_ready_latency: assert property ($fell(stb_n) |-> ##[1:12] !port_ready_n)
		else $error("ready late");
	chk_strobe_hold: assert property ($rose(stb_n) |-> $past(port_ready_n) == 1'b0)
		else $error("strobe released before ready");
	chk_gap_min: assert property ($rose(stb_n) |-> stb_n [*3])
		else $error("strobe gap short");
	chk_sel_stable: assert property ((!stb_n && $past(stb_n) == 1'b0) |->
		$stable(access_type_select) && $stable(read_write_select)
		&& $stable(halfword_select))
		else $error("selects moved in access");
	chk_ready_idle: assert property ((stb_n && $past(stb_n) && $past(stb_n, 2)) |->
		port_ready_n)
		else $error("ready low while idle");
	chk_oe_read: assert property ($rose(dev_data_oe) |-> !stb_n && read_write_select)
		else $error("data driven outside read");
	chk_interrupt_to_host_sticky: assert property (interrupt_to_host |=> interrupt_to_host)
		else $error("host interrupt dropped");
	cover property ($fell(port_ready_n) && read_write_select);
	cover property ($fell(port_ready_n) && halfword_select);
	cover property ($rose(interrupt_to_host));
endmodule : host_port_assertions

// File: test/host_port_interface_tb_top.sv
`timescale 1ns/1ps
module host_port_interface_tb_top;
	import host_port_pkg::*;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic strap = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [31:0] adr = 32'h0000_0000, wdat = 32'h0000_0000, rdat, q, rspd;
	logic ack, err, werr, irq, rr, rspv, hirq;
	logic rv = 1'b0, rw = 1'b0, rwide = 1'b1;
	logic [1:0] rsel = 2'h0;
	logic [31:0] rdata = 32'h0000_0000;
	int err_total = 0, checked = 0, cyc_cnt = 0;
	always #25 ref_clk = ~ref_clk;
	host_port_if link ();
	host_port_device host_port_device_i (.REF_CLK(ref_clk), .NRST(nrst),
		.WIDTH_STRAP_PIN(strap), .HOST(link), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.WB_ERR_O(err), .IRQ_O(irq));
	host_port_host host_port_host_i (.REF_CLK(ref_clk), .NRST(nrst), .LINK(link),
		.REQ_VALID(rv), .REQ_READY(rr), .REQ_WRITE(rw), .REQ_WIDE(rwide), .REQ_SEL(rsel),
		.REQ_DATA(rdata), .RSP_VALID(rspv), .RSP_DATA(rspd), .HOST_IRQ(hirq));
	host_port_assertions host_port_assertions_i (.REF_CLK(ref_clk), .NRST(nrst),
		.port_select_n(link.port_select_n), .data_strobe_a(link.data_strobe_a),
		.data_strobe_b(link.data_strobe_b), .access_type_select(link.access_type_select),
		.read_write_select(link.read_write_select), .halfword_select(link.halfword_select),
		.dev_data_oe(link.dev_data_oe), .port_ready_n(link.port_ready_n),
		.interrupt_to_host(link.interrupt_to_host));
	// ==========================================
	// Shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge ref_clk);
		end while (ack !== 1'b1 && err !== 1'b1);
		q = rdat;
		werr = err;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic host(input logic w, input logic [1:0] s, input logic [31:0] d);
		@(posedge ref_clk);
		rv <= 1'b1;
		rw <= w;
		rsel <= s;
		rdata <= d;
		do begin
			@(posedge ref_clk);
		end while (rr !== 1'b1);
		rv <= 1'b0;
		do begin
			@(posedge ref_clk);
		end while (rspv !== 1'b1);
		q = rspd;
	endtask : host
	task automatic do_reset(input logic s);
		nrst <= 1'b0;
		strap <= s;
		rwide <= s;
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask : do_reset
	task automatic conclude;
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	// ==========================================
	// Scenarios
	task automatic t_regs;
		wb(0, OFS_PORT_CTRL, 32'h0000_0000);
		check(q, CTRL_RESET);
		wb(0, OFS_POWER_EMU, 32'h0000_0000);
		check(q, POWER_RESET);
		wb(1, OFS_POWER_EMU, 32'h1234_5678);
		host(0, SEL_POWER, 32'h0000_0000);
		check(q, 32'h1234_5678);
		host(1, SEL_POWER, 32'h0000_00a5);
		wb(0, OFS_POWER_EMU, 32'h0000_0000);
		check(q, 32'h0000_00a5);
		wb(0, 32'h0288_0000, 32'h0000_0000);
		check({31'h0, werr}, 32'h0000_0001);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_addr;
		host(1, SEL_ADDR, 32'h0000_0010);
		wb(0, OFS_WRITE_ADDR, 32'h0000_0000);
		check(q, 32'h0000_0010);
		wb(0, OFS_READ_ADDR, 32'h0000_0000);
		check(q, 32'h0000_0010);
		wb(1, OFS_WRITE_ADDR, 32'hffff_ffff);
		wb(0, OFS_WRITE_ADDR, 32'h0000_0000);
		check(q, 32'h0000_0010);
		host(1, SEL_DATA, 32'ha5a5_5a5a);
		host(0, SEL_DATA, 32'h0000_0000);
		check(q, 32'ha5a5_5a5a);
		wb(1, OFS_PORT_CTRL, 32'h0000_0001);
		host(0, SEL_CTRL, 32'h0000_0000);
		check({31'h0, q[CTRL_DUAL_BIT]}, 32'h0000_0001);
		host(1, SEL_ADDR, 32'h0000_0020);
		wb(0, OFS_WRITE_ADDR, 32'h0000_0000);
		check(q, 32'h0000_0020);
		wb(0, OFS_READ_ADDR, 32'h0000_0000);
		check(q, 32'h0000_0010);
		wb(1, OFS_PORT_CTRL, 32'h0000_0011);
		host(1, SEL_ADDR, 32'h0000_0040);
		wb(0, OFS_READ_ADDR, 32'h0000_0000);
		check(q, 32'h0000_0040);
		wb(0, OFS_WRITE_ADDR, 32'h0000_0000);
		check(q, 32'h0000_0020);
		wb(1, OFS_PORT_CTRL, 32'h0000_0000);
		$display("t_addr done");
	endtask : t_addr
	task automatic t_irq;
		wb(1, OFS_IRQ_MASK, 32'h0000_0000);
		wb(0, OFS_IRQ_STATUS, 32'h0000_0000);
		host(1, SEL_CTRL, 32'h0000_0002);
		repeat (2) @(posedge ref_clk);
		check({31'h0, irq}, 32'h0000_0000);
		wb(1, OFS_IRQ_MASK, 32'h0000_0003);
		repeat (2) @(posedge ref_clk);
		check({31'h0, irq}, 32'h0000_0001);
		wb(0, OFS_IRQ_STATUS, 32'h0000_0000);
		check(q & 32'h0000_0003, 32'h0000_0003);
		wb(0, OFS_DMA_EVENT, 32'h0000_0000);
		check({31'h0, q[DMA_BOOT_CH]}, 32'h0000_0001);
		wb(1, OFS_DMA_EVENT, 32'h0000_0001);
		wb(0, OFS_DMA_EVENT, 32'h0000_0000);
		check({31'h0, q[DMA_BOOT_CH]}, 32'h0000_0000);
		wb(1, OFS_PORT_CTRL, 32'h0000_0002);
		host(0, SEL_CTRL, 32'h0000_0000);
		check({31'h0, q[CTRL_FROM_HOST_BIT]}, 32'h0000_0000);
		check({31'h0, irq}, 32'h0000_0000);
		wb(1, OFS_PORT_CTRL, 32'h0000_0004);
		repeat (3) @(posedge ref_clk);
		check({31'h0, hirq}, 32'h0000_0001);
		wb(0, OFS_PORT_CTRL, 32'h0000_0000);
		check({30'h0, q[3:2]}, 32'h0000_0001);
		$display("t_irq done");
	endtask : t_irq
	task automatic t_narrow;
		do_reset(1'b0);
		host(1, SEL_ADDR, 32'h0000_0030);
		host(1, SEL_DATA, 32'h1357_9bdf);
		host(0, SEL_DATA, 32'h0000_0000);
		check(q, 32'h1357_9bdf);
		wb(0, OFS_WRITE_ADDR, 32'h0000_0000);
		check(q, 32'h0000_0030);
		$display("t_narrow done");
	endtask : t_narrow
	always @(posedge ref_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_total++;
			conclude();
		end
	end
	initial begin
		do_reset(1'b1);
		t_regs();
		t_addr();
		t_irq();
		t_narrow();
		conclude();
	end
endmodule : host_port_interface_tb_top
